// ===== resf_defines.svh
// Constants for the rail enable sequencer: offsets, fields, reset values and timing.
// Functional notes
// - Enable register bits gate each rail
// - Separate writes take effect separately
// - Written enables take effect at bus stop
// - Negative rail lags 2ms unless bit 6
// - Default enable bits let pins switch rails
// - Tied pins high: positive first, negative later
// - Tied pins low: negative off, positive later
// - Current limit ends the switch cycle only
// - Input lockout stops everything, restart after
// - Input lockout keeps register contents
// - Over-temperature stops everything, auto restart
// - Over-temperature latches fault bit 0 only
// - Pin cycle or power cycle clears flag
// - Second fault read clears temperature flag
// - Undervoltage checks off during over-temperature
// - Undervoltage needs qualification time to fault
// - Undervoltage fault bits 3,2,1, pin-cycle clear
// - Config bit 5 disables undervoltage protection
// - Config bit 4 selects delayed or immediate off
`ifndef RESF_DEFINES_SVH
`define RESF_DEFINES_SVH

`define RESF_CLK_PERIOD_NS   10
`define RESF_SEQ_DELAY_NS    2000000
`define RESF_UVP_QUAL_NS     100000
`define RESF_SEQ_DELAY_CYC   (`RESF_SEQ_DELAY_NS / `RESF_CLK_PERIOD_NS)
`define RESF_UVP_QUAL_CYC    ((`RESF_UVP_QUAL_NS + `RESF_CLK_PERIOD_NS - 1) / `RESF_CLK_PERIOD_NS)

`define RESF_DEV_ADDR        7'h29
`define RESF_OFS_ENABLE      8'h02
`define RESF_OFS_FAULT       8'h04
`define RESF_OFS_CONFIG      8'h05
`define RESF_ENABLE_RST      8'h07
`define RESF_CONFIG_RST      8'h07
`define RESF_FAULT_RST       4'h0
`define RESF_READ_NONE       8'h00

`define RESF_EN_NEG_BIT      1
`define RESF_EN_POS_BIT      2
`define RESF_EN_NODELAY_BIT  6
`define RESF_FLT_OTP_BIT     0
`define RESF_FLT_BST_BIT     1
`define RESF_FLT_NEG_BIT     2
`define RESF_FLT_POS_BIT     3
`define RESF_CFG_FASTOFF_BIT 4
`define RESF_CFG_UVPDIS_BIT  5

`define RESF_BITCNT_FULL     4'h8
`define RESF_BITCNT_LAST     4'h7

`endif

// ===== resf_pkg.sv
// Types shared by the rail enable sequencer.
package resf_pkg;
    typedef enum logic [3:0] {
        RESF_IDLE   = 4'b0000,
        RESF_ADDR   = 4'b0001,
        RESF_ACK_A  = 4'b0010,
        RESF_REG    = 4'b0011,
        RESF_ACK_R  = 4'b0100,
        RESF_WDATA  = 4'b0101,
        RESF_ACK_W  = 4'b0110,
        RESF_RDATA  = 4'b0111,
        RESF_RACK   = 4'b1000
    } resf_bus_e;
endpackage : resf_pkg

// ===== resf_hold_if.sv
// Handshake between a user and a hold-time qualifier.
`timescale 1ns/10ps
interface resf_hold_if;
    logic arm;
    logic done;
    modport timer (input arm, output done);
    modport user  (output arm, input done);
endinterface : resf_hold_if

// ===== resf_hold_timer.sv
// Qualifier that reports a condition held for a fixed number of cycles.
`timescale 1ns/10ps
module resf_hold_timer #(
    parameter int unsigned CYCLES = 1
) (
    input  wire logic     sys_clk_i,
    input  wire logic     sys_rst_i,
    resf_hold_if.timer    hold
);
    localparam int unsigned W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LIMIT = W'(CYCLES);

    logic [W-1:0] cnt_r;

    // Any drop of arm restarts the count, so short excursions never finish.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !hold.arm) begin
            cnt_r <= '0;
        end else if (cnt_r != LIMIT) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign hold.done = hold.arm && (cnt_r == LIMIT);

    a_done_needs_time : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(hold.done) |-> $past(hold.arm))
        else $error("Hold qualifier finished without a held condition.");
endmodule : resf_hold_timer

// ===== resf_top.sv
// Rail enable sequencer with two-wire register access and fault latching.
`timescale 1ns/10ps
`include "resf_defines.svh"
module resf_top #(
    parameter int unsigned SEQ_DELAY_CYC = `RESF_SEQ_DELAY_CYC,
    parameter int unsigned UVP_QUAL_CYC  = `RESF_UVP_QUAL_CYC,
    parameter logic [6:0]  DEV_ADDR      = `RESF_DEV_ADDR
) (
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       pos_rail_enable_pin_i,
    input  wire logic       neg_rail_enable_pin_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output      logic       sda_o,
    output      logic       sda_oe_o,
    input  wire logic       input_undervoltage_lockout_i,
    input  wire logic       over_temp_i,
    input  wire logic [2:0] output_undervoltage_raw_i,
    input  wire logic       switch_current_limit_i,
    input  wire logic       boost_pwm_i,
    output      logic       boost_stage_en_o,
    output      logic       positive_rail_en_o,
    output      logic       negative_rail_en_o,
    output      logic       boost_switch_o
);
    // Every pin is asynchronous to sys_clk_i; only the second stage is used.
    localparam int unsigned NSYNC = 11;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    logic             scl_prev_r;
    logic             sda_prev_r;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sync1_r    <= '0;
            sync2_r    <= '0;
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            sync1_r    <= {boost_pwm_i, switch_current_limit_i, output_undervoltage_raw_i, over_temp_i,
                           input_undervoltage_lockout_i, sda_i, scl_i, neg_rail_enable_pin_i,
                           pos_rail_enable_pin_i};
            sync2_r    <= sync1_r;
            scl_prev_r <= sync2_r[2];
            sda_prev_r <= sync2_r[3];
        end
    end

    logic       pos_pin_s;
    logic       neg_pin_s;
    logic       scl_s;
    logic       sda_s;
    logic       input_undervoltage_lockout_s;
    logic       otp_s;
    logic [2:0] uvp_s;
    logic       ilim_s;
    logic       pwm_s;
    assign pos_pin_s = sync2_r[0];
    assign neg_pin_s = sync2_r[1];
    assign scl_s     = sync2_r[2];
    assign sda_s     = sync2_r[3];
    assign input_undervoltage_lockout_s    = sync2_r[4];
    assign otp_s     = sync2_r[5];
    assign uvp_s     = sync2_r[8:6];
    assign ilim_s    = sync2_r[9];
    assign pwm_s     = sync2_r[10];

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise  = scl_s && !scl_prev_r;
    assign scl_fall  = !scl_s && scl_prev_r;
    assign start_det = scl_s && scl_prev_r && sda_prev_r && !sda_s;
    assign stop_det  = scl_s && scl_prev_r && !sda_prev_r && sda_s;

    // Registers; the lockout input never reaches them, only sys_rst_i does.
    logic [7:0] en_r;
    logic [7:0] cfg_r;
    logic [3:0] fault_r;
    logic [7:0] pend_en_r;
    logic [7:0] pend_cfg_r;
    logic       pend_en_v_r;
    logic       pend_cfg_v_r;

    resf_pkg::resf_bus_e state_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [7:0] ptr_r;
    logic [3:0] bitcnt_r;
    logic       rw_r;
    logic       ack_r;
    logic       sda_oe_r;
    logic       rd_load;
    logic [7:0] rd_data;

    always_comb begin
        case (ptr_r)
            `RESF_OFS_ENABLE: rd_data = en_r;
            `RESF_OFS_FAULT:  rd_data = {4'h0, fault_r};
            `RESF_OFS_CONFIG: rd_data = cfg_r;
            default:          rd_data = `RESF_READ_NONE;
        endcase
    end

    // A read byte is fetched on the falling clock that ends an acknowledge.
    assign rd_load = scl_fall && ((state_r == resf_pkg::RESF_ACK_A && rw_r) ||
                                  (state_r == resf_pkg::RESF_RACK && ack_r));

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_r  <= resf_pkg::RESF_IDLE;
            shift_r  <= '0;
            tx_r     <= '0;
            ptr_r    <= '0;
            bitcnt_r <= '0;
            rw_r     <= 1'b0;
            ack_r    <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (start_det) begin
            state_r  <= resf_pkg::RESF_ADDR;
            bitcnt_r <= '0;
            sda_oe_r <= 1'b0;
        end else if (stop_det) begin
            state_r  <= resf_pkg::RESF_IDLE;
            sda_oe_r <= 1'b0;
        end else if (scl_rise) begin
            if (state_r == resf_pkg::RESF_RACK) begin
                ack_r <= !sda_s;
            end else if (state_r == resf_pkg::RESF_ADDR || state_r == resf_pkg::RESF_REG ||
                         state_r == resf_pkg::RESF_WDATA) begin
                shift_r  <= {shift_r[6:0], sda_s};
                bitcnt_r <= bitcnt_r + 1'b1;
            end
        end else if (scl_fall) begin
            case (state_r)
                resf_pkg::RESF_ADDR: begin
                    if (bitcnt_r == `RESF_BITCNT_FULL) begin
                        if (shift_r[7:1] == DEV_ADDR) begin
                            rw_r     <= shift_r[0];
                            sda_oe_r <= 1'b1;
                            state_r  <= resf_pkg::RESF_ACK_A;
                        end else begin
                            state_r <= resf_pkg::RESF_IDLE;
                        end
                    end
                end
                resf_pkg::RESF_ACK_A: begin
                    bitcnt_r <= '0;
                    if (rw_r) begin
                        tx_r     <= {rd_data[6:0], 1'b0};
                        sda_oe_r <= !rd_data[7];
                        state_r  <= resf_pkg::RESF_RDATA;
                    end else begin
                        sda_oe_r <= 1'b0;
                        state_r  <= resf_pkg::RESF_REG;
                    end
                end
                resf_pkg::RESF_REG: begin
                    if (bitcnt_r == `RESF_BITCNT_FULL) begin
                        ptr_r    <= shift_r;
                        sda_oe_r <= 1'b1;
                        state_r  <= resf_pkg::RESF_ACK_R;
                    end
                end
                resf_pkg::RESF_WDATA: begin
                    if (bitcnt_r == `RESF_BITCNT_FULL) begin
                        sda_oe_r <= 1'b1;
                        state_r  <= resf_pkg::RESF_ACK_W;
                    end
                end
                resf_pkg::RESF_ACK_R, resf_pkg::RESF_ACK_W: begin
                    if (state_r == resf_pkg::RESF_ACK_W) begin
                        ptr_r <= ptr_r + 1'b1;
                    end
                    bitcnt_r <= '0;
                    sda_oe_r <= 1'b0;
                    state_r  <= resf_pkg::RESF_WDATA;
                end
                resf_pkg::RESF_RDATA: begin
                    if (bitcnt_r == `RESF_BITCNT_LAST) begin
                        sda_oe_r <= 1'b0;
                        ptr_r    <= ptr_r + 1'b1;
                        state_r  <= resf_pkg::RESF_RACK;
                    end else begin
                        bitcnt_r <= bitcnt_r + 1'b1;
                        sda_oe_r <= !tx_r[7];
                        tx_r     <= {tx_r[6:0], 1'b0};
                    end
                end
                resf_pkg::RESF_RACK: begin
                    bitcnt_r <= '0;
                    if (ack_r) begin
                        tx_r     <= {rd_data[6:0], 1'b0};
                        sda_oe_r <= !rd_data[7];
                        state_r  <= resf_pkg::RESF_RDATA;
                    end else begin
                        state_r <= resf_pkg::RESF_IDLE;
                    end
                end
                default: state_r <= resf_pkg::RESF_IDLE;
            endcase
        end
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = sda_oe_r;

    // Written bytes wait in a staging copy; a stop commits them, so one transaction moves rails together.
    logic wr_byte;
    assign wr_byte = scl_fall && !start_det && !stop_det && state_r == resf_pkg::RESF_WDATA &&
                     bitcnt_r == `RESF_BITCNT_FULL;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            en_r         <= `RESF_ENABLE_RST;
            cfg_r        <= `RESF_CONFIG_RST;
            pend_en_r    <= `RESF_ENABLE_RST;
            pend_cfg_r   <= `RESF_CONFIG_RST;
            pend_en_v_r  <= 1'b0;
            pend_cfg_v_r <= 1'b0;
        end else if (stop_det) begin
            if (pend_en_v_r) begin
                en_r <= pend_en_r;
            end
            if (pend_cfg_v_r) begin
                cfg_r <= pend_cfg_r;
            end
            pend_en_v_r  <= 1'b0;
            pend_cfg_v_r <= 1'b0;
        end else if (wr_byte) begin
            if (ptr_r == `RESF_OFS_ENABLE) begin
                pend_en_r   <= shift_r;
                pend_en_v_r <= 1'b1;
            end
            if (ptr_r == `RESF_OFS_CONFIG) begin
                pend_cfg_r   <= shift_r;
                pend_cfg_v_r <= 1'b1;
            end
        end
    end

    // Rail control.
    logic kill;
    logic pos_req;
    logic neg_req;
    logic pos_on_r;
    logic neg_on_r;
    logic boost_on;
    assign kill    = input_undervoltage_lockout_s || otp_s;
    assign pos_req = pos_pin_s && en_r[`RESF_EN_POS_BIT] && !kill &&
                     !fault_r[`RESF_FLT_POS_BIT] && !fault_r[`RESF_FLT_BST_BIT];
    assign neg_req = neg_pin_s && en_r[`RESF_EN_NEG_BIT] && !kill &&
                     !fault_r[`RESF_FLT_NEG_BIT] && !fault_r[`RESF_FLT_BST_BIT];

    resf_hold_if neg_dly_if ();
    resf_hold_if pos_off_if ();
    assign neg_dly_if.arm = neg_req && !neg_on_r;
    assign pos_off_if.arm = pos_on_r && !pos_req && !cfg_r[`RESF_CFG_FASTOFF_BIT];

    resf_hold_timer #(.CYCLES(SEQ_DELAY_CYC)) u_neg_dly (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .hold      (neg_dly_if.timer)
    );
    resf_hold_timer #(.CYCLES(SEQ_DELAY_CYC)) u_pos_off (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .hold      (pos_off_if.timer)
    );

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || kill || fault_r[`RESF_FLT_POS_BIT] || fault_r[`RESF_FLT_BST_BIT]) begin
            pos_on_r <= 1'b0;
        end else if (pos_req) begin
            pos_on_r <= 1'b1;
        end else if (cfg_r[`RESF_CFG_FASTOFF_BIT] || pos_off_if.done) begin
            pos_on_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !neg_req) begin
            neg_on_r <= 1'b0;
        end else if (en_r[`RESF_EN_NODELAY_BIT] || neg_dly_if.done) begin
            neg_on_r <= 1'b1;
        end
    end

    // The boost stays up while either rail runs or the negative rail waits to start.
    assign boost_on = pos_on_r || neg_on_r || neg_req;

    // Current limit only trims the present switch cycle; no rail reacts to it.
    logic pwm_prev_r;
    logic ilim_hold_r;
    logic boost_sw_r;
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pwm_prev_r  <= 1'b0;
            ilim_hold_r <= 1'b0;
            boost_sw_r  <= 1'b0;
        end else begin
            pwm_prev_r  <= pwm_s;
            if (ilim_s) begin
                ilim_hold_r <= 1'b1;
            end else if (pwm_s && !pwm_prev_r) begin
                ilim_hold_r <= 1'b0;
            end
            boost_sw_r  <= boost_on && pwm_s && !ilim_s && !ilim_hold_r;
        end
    end

    // Output undervoltage qualification for positive, negative and boost.
    logic [2:0] rail_on;
    logic [2:0] uvp_done;
    assign rail_on = {pos_on_r, neg_on_r, boost_on};
    resf_hold_if uvp_if [3] ();
    for (genvar g = 0; g < 3; g++) begin : g_uvp
        assign uvp_if[g].arm = uvp_s[g] && rail_on[g] && !otp_s &&
                               !cfg_r[`RESF_CFG_UVPDIS_BIT];
        assign uvp_done[g]   = uvp_if[g].done;
        resf_hold_timer #(.CYCLES(UVP_QUAL_CYC)) u_uvp (
            .sys_clk_i (sys_clk_i),
            .sys_rst_i (sys_rst_i),
            .hold      (uvp_if[g].timer)
        );
    end

    // Fault flags: clears come first so a coincident event still sets.
    logic both_low_r;
    logic pin_cycle;
    logic otp_prev_r;
    logic otp_read1_r;
    logic flt_read;
    assign pin_cycle = both_low_r && pos_pin_s && neg_pin_s;
    assign flt_read  = rd_load && ptr_r == `RESF_OFS_FAULT;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            fault_r     <= `RESF_FAULT_RST;
            both_low_r  <= 1'b0;
            otp_prev_r  <= 1'b0;
            otp_read1_r <= 1'b0;
        end else begin
            otp_prev_r <= otp_s;
            if (!pos_pin_s && !neg_pin_s) begin
                both_low_r <= 1'b1;
            end else if (pos_pin_s && neg_pin_s) begin
                both_low_r <= 1'b0;
            end
            if (pin_cycle) begin
                fault_r     <= `RESF_FAULT_RST;
                otp_read1_r <= 1'b0;
            end else if (flt_read && fault_r[`RESF_FLT_OTP_BIT]) begin
                otp_read1_r <= !otp_read1_r;
                if (otp_read1_r) begin
                    fault_r[`RESF_FLT_OTP_BIT] <= 1'b0;
                end
            end
            if (otp_s && !otp_prev_r) begin
                fault_r[`RESF_FLT_OTP_BIT] <= 1'b1;
                otp_read1_r                <= 1'b0;
            end
            if (uvp_done[2]) fault_r[`RESF_FLT_POS_BIT] <= 1'b1;
            if (uvp_done[1]) fault_r[`RESF_FLT_NEG_BIT] <= 1'b1;
            if (uvp_done[0]) fault_r[`RESF_FLT_BST_BIT] <= 1'b1;
        end
    end

    assign boost_stage_en_o   = boost_on;
    assign positive_rail_en_o = pos_on_r;
    assign negative_rail_en_o = neg_on_r;
    assign boost_switch_o     = boost_sw_r;

    a_kill_rails_off : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        input_undervoltage_lockout_s ##1 input_undervoltage_lockout_s |-> !pos_on_r && !neg_on_r && !boost_on)
        else $error("Rails still on after input lockout.");
    a_otp_rails_off : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        otp_s |=> !pos_on_r && !neg_on_r)
        else $error("Rails still on during over-temperature.");
    a_otp_flag_set : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(otp_s) |=> fault_r[`RESF_FLT_OTP_BIT] && fault_r[3:1] == $past(fault_r[3:1]))
        else $error("Over-temperature flag not latched alone.");
    a_uvp_otp_quiet : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        otp_s ##1 otp_s |-> (fault_r[3:1] & ~$past(fault_r[3:1])) == 3'b000)
        else $error("Undervoltage fault raised during over-temperature.");
    a_uvp_disabled : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        cfg_r[`RESF_CFG_UVPDIS_BIT] ##1 cfg_r[`RESF_CFG_UVPDIS_BIT] |-> (fault_r[3:1] & ~$past(fault_r[3:1])) == 3'b000)
        else $error("Undervoltage fault raised while protection disabled.");
    a_enable_at_stop : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $changed(en_r) |-> $past(stop_det))
        else $error("Enable register changed outside a stop.");
    a_pos_off_delay : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        pos_on_r && !pos_req && !kill && !cfg_r[`RESF_CFG_FASTOFF_BIT] && $past(pos_req)
        && fault_r == $past(fault_r) |=> pos_on_r [*2])
        else $error("Positive rail turned off without the delay.");
    a_neg_off_fast : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !neg_req |=> !neg_on_r)
        else $error("Negative rail stayed on without a request.");
    a_neg_start_lag : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(neg_on_r) && !$past(en_r[`RESF_EN_NODELAY_BIT]) |-> $past(neg_dly_if.done))
        else $error("Negative rail started before its delay.");
    a_ilim_cuts_sw : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ilim_s |=> !boost_sw_r)
        else $error("Switch kept on at the current limit.");

    c_tied_start : cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(pos_on_r) ##[1:1000] $rose(neg_on_r));
    c_otp_clear_read : cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $fell(fault_r[`RESF_FLT_OTP_BIT]) && !pin_cycle);
    c_uvp_fault : cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(fault_r[`RESF_FLT_POS_BIT]));
    c_bus_write : cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        stop_det && pend_en_v_r);
endmodule : resf_top

// ===== resf_host_model.sv
// Host processor model driving the enable pins and the two-wire bus.
`timescale 1ns/10ps
`include "resf_defines.svh"
module resf_host_model (
    input  wire logic sys_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o,
    output logic      pos_pin_o,
    output logic      neg_pin_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        pos_pin_o = 1'b0;
        neg_pin_o = 1'b0;
    end
    // Eight clocks per bus phase keeps well above the three the sampler needs.
    task automatic gap;
        repeat (8) @(negedge sys_clk_i);
    endtask : gap
    // Both pins move together, as a host with one GPIO would drive them.
    task automatic pins(input logic v);
        @(negedge sys_clk_i);
        pos_pin_o = v;
        neg_pin_o = v;
    endtask : pins
    task automatic start;
        sda_o = 1'b1;
        gap;
        scl_o = 1'b1;
        gap;
        sda_o = 1'b0;
        gap;
        scl_o = 1'b0;
        gap;
    endtask : start
    task automatic stop;
        sda_o = 1'b0;
        gap;
        scl_o = 1'b1;
        gap;
        sda_o = 1'b1;
        gap;
    endtask : stop
    task automatic bit_io(input logic b, output logic r);
        sda_o = b;
        gap;
        scl_o = 1'b1;
        gap;
        r = sda_i;
        scl_o = 1'b0;
        gap;
    endtask : bit_io
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q);
        logic k;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(a, k);
    endtask : xfer
    task automatic reg_write(input logic [7:0] ofs, input logic [7:0] val, input logic fin);
        logic [7:0] q;
        start;
        xfer({`RESF_DEV_ADDR, 1'b0}, 1'b1, q);
        xfer(ofs, 1'b1, q);
        xfer(val, 1'b1, q);
        if (fin) begin
            stop;
        end
    endtask : reg_write
    task automatic reg_read(input logic [7:0] ofs, output logic [7:0] q);
        start;
        xfer({`RESF_DEV_ADDR, 1'b0}, 1'b1, q);
        xfer(ofs, 1'b1, q);
        start;
        xfer({`RESF_DEV_ADDR, 1'b1}, 1'b1, q);
        xfer(8'hff, 1'b1, q);
        stop;
    endtask : reg_read
endmodule : resf_host_model

// ===== tb_top.sv
// Self-checking testbench for the rail enable sequencer.
`timescale 1ns/10ps
module tb_top;
    localparam int unsigned SEQ = 20;
    logic       sys_clk_i;
    logic       sys_rst_i;
    logic       lockout;
    logic       otp;
    logic [2:0] uv_raw;
    logic       scl;
    logic       sda_host;
    logic       sda_oe;
    logic       pos_pin;
    logic       neg_pin;
    logic       bst_en;
    logic       pos_en;
    logic       neg_en;
    logic [7:0] rd;
    logic       ilim;
    logic       pwm;
    logic       sw;
    logic       sda_dev;
    int         fail_count;
    int         tests_run;
    // Open-drain line with a pull-up: low when either side pulls.
    wire logic  sda_wire = sda_host & (sda_dev | ~sda_oe);

    resf_top #(.SEQ_DELAY_CYC(SEQ), .UVP_QUAL_CYC(8)) u_resf_top (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .pos_rail_enable_pin_i(pos_pin),
        .neg_rail_enable_pin_i(neg_pin), .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_dev), .sda_oe_o(sda_oe),
        .input_undervoltage_lockout_i(lockout), .over_temp_i(otp), .output_undervoltage_raw_i(uv_raw),
        .switch_current_limit_i(ilim), .boost_pwm_i(pwm), .boost_stage_en_o(bst_en),
        .positive_rail_en_o(pos_en), .negative_rail_en_o(neg_en), .boost_switch_o(sw));
    resf_host_model u_resf_host_model (.sys_clk_i(sys_clk_i), .sda_i(sda_wire), .scl_o(scl),
        .sda_o(sda_host), .pos_pin_o(pos_pin), .neg_pin_o(neg_pin));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : cyc
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask : chk
    task automatic final_report;
        if (fail_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    task automatic t_tied;
        u_resf_host_model.pins(1'b1);
        cyc(6);
        chk("pos_on", 8'h01, 8'(pos_en));
        chk("neg_wait", 8'h00, 8'(neg_en));
        cyc(SEQ);
        chk("neg_on", 8'h01, 8'(neg_en));
        u_resf_host_model.pins(1'b0);
        cyc(6);
        chk("neg_off", 8'h00, 8'(neg_en));
        chk("pos_hold", 8'h01, 8'(pos_en));
        cyc(SEQ);
        chk("pos_off", 8'h00, 8'(pos_en));
    endtask : t_tied
    task automatic t_bus;
        u_resf_host_model.reg_read(8'h02, rd);
        chk("enable_default", 8'h07, rd);
        u_resf_host_model.pins(1'b1);
        cyc(SEQ + 6);
        u_resf_host_model.reg_write(8'h02, 8'h04, 1'b0);
        chk("neg_before_stop", 8'h01, 8'(neg_en));
        u_resf_host_model.stop;
        cyc(6);
        chk("neg_bit_off", 8'h00, 8'(neg_en));
        chk("pos_bit_on", 8'h01, 8'(pos_en));
        u_resf_host_model.reg_write(8'h02, 8'h46, 1'b1);
        cyc(6);
        chk("neg_no_lag", 8'h01, 8'(neg_en));
        u_resf_host_model.reg_read(8'h10, rd);
        chk("unmapped", 8'h00, rd);
    endtask : t_bus
    task automatic t_faults;
        otp = 1'b1;
        cyc(6);
        chk("otp_off", 8'h00, {5'h00, bst_en, pos_en, neg_en});
        otp = 1'b0;
        cyc(6);
        chk("otp_restart", 8'h03, {6'h00, pos_en, neg_en});
        u_resf_host_model.reg_read(8'h04, rd);
        chk("otp_flag", 8'h01, rd);
        u_resf_host_model.reg_read(8'h04, rd);
        chk("otp_read2", 8'h01, rd);
        u_resf_host_model.reg_read(8'h04, rd);
        chk("otp_read_clr", 8'h00, rd);
        lockout = 1'b1;
        cyc(6);
        chk("lockout_off", 8'h00, {5'h00, bst_en, pos_en, neg_en});
        lockout = 1'b0;
        cyc(6);
        chk("lockout_back", 8'h03, {6'h00, pos_en, neg_en});
        u_resf_host_model.reg_read(8'h02, rd);
        chk("enable_kept", 8'h46, rd);
    endtask : t_faults
    task automatic t_uvp;
        uv_raw = 3'h4;
        cyc(4);
        uv_raw = 3'h0;
        cyc(6);
        chk("short_dip", 8'h01, 8'(pos_en));
        uv_raw = 3'h4;
        cyc(20);
        uv_raw = 3'h0;
        chk("uv_off", 8'h00, 8'(pos_en));
        u_resf_host_model.reg_read(8'h04, rd);
        chk("uv_flag", 8'h08, rd);
        u_resf_host_model.pins(1'b0);
        cyc(6);
        u_resf_host_model.pins(1'b1);
        cyc(6);
        u_resf_host_model.reg_read(8'h04, rd);
        chk("uv_clear", 8'h00, rd);
        chk("uv_back", 8'h01, 8'(pos_en));
    endtask : t_uvp
    task automatic t_cfg;
        u_resf_host_model.reg_write(8'h05, 8'h37, 1'b1);
        u_resf_host_model.pins(1'b0);
        cyc(6);
        chk("fast_off", 8'h00, {6'h00, pos_en, neg_en});
        u_resf_host_model.pins(1'b1);
        uv_raw = 3'h7;
        cyc(30);
        uv_raw = 3'h0;
        chk("uvp_masked", 8'h07, {5'h00, bst_en, pos_en, neg_en});
    endtask : t_cfg
    task automatic t_ilim;
        pwm = 1'b1;
        cyc(6);
        chk("sw_on", 8'h01, 8'(sw));
        ilim = 1'b1;
        cyc(6);
        chk("sw_cut", 8'h00, 8'(sw));
        ilim = 1'b0;
        cyc(6);
        chk("sw_held", 8'h00, 8'(sw));
        chk("ilim_rails", 8'h07, {5'h00, bst_en, pos_en, neg_en});
        pwm = 1'b0;
        cyc(6);
        pwm = 1'b1;
        cyc(6);
        chk("sw_resume", 8'h01, 8'(sw));
    endtask : t_ilim
    initial begin
        fail_count = 0;
        tests_run = 0;
        sys_rst_i = 1'b1;
        lockout = 1'b0;
        otp = 1'b0;
        uv_raw = 3'h0;
        ilim = 1'b0;
        pwm = 1'b0;
        cyc(6);
        sys_rst_i = 1'b0;
        cyc(3);
        t_tied;
        t_bus;
        t_faults;
        t_uvp;
        t_cfg;
        t_ilim;
        final_report;
    end
    // The scenarios need about 10000 cycles; 33000, over three times that, marks a hang.
    initial begin
        #330000;
        fail_count++;
        final_report;
    end
endmodule : tb_top
